// File: test_tswseq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_tswseq_sequencer;
	import tswseq_pkg::*;
	logic mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmdValid, cmdReady;
	logic respValid, respAck, tear_protect_enable, eeReq, eeWrite, eeDone, slow, flagQ;
	logic [3:0] wb_adr_i, wb_sel_i, zoneSel, z;
	logic [31:0] wb_dat_i, wb_dat_o;
	tswseq_op_type cmdOp;
	tswseq_area_type eeArea, eeTag, eeRtag;
	logic [7:0] command_parameter_byte;
	logic [15:0] cmdAddr, eeAddr, eeRaddr;
	logic [4:0] cmdLen, eeLen, eeRlen;
	logic [255:0] cmdData, eeWdata, eeRdata, tgtQ;
	logic [63:0] d;
	logic expQ[$];
	int miscompares, nCompared, cycles, seed;
	tswseq_sequencer dut_u (.*);
	tswseq_nvm_model nvm_u (.*);
	always #20 mclk = ~mclk;
	task automatic chk(input logic [255:0] a, input logic [255:0] e);
		nCompared++;
		if (a !== e) begin
			miscompares++;
			$display("BAD %0t got %0h want %0h", $time, a, e);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			complete_run;
		end
		if (respValid === 1'b1) chk(respAck, expQ.size() ? expQ.pop_front() : 1'bx);
	end
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] v);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, v};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		if (!we) chk(wb_dat_o, v);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge mclk);
	endtask
	task automatic cmd(tswseq_op_type o, logic [7:0] p, logic [4:0] l, logic e);
		cmdOp <= o;
		command_parameter_byte <= p;
		cmdLen <= l;
		cmdValid <= 1'b1;
		cmdData <= {192'h0, d};
		expQ.push_back(e);
		do @(posedge mclk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic idle;
		do @(posedge mclk); while (cmdReady !== 1'b1);
	endtask
	task automatic tear(tswseq_area_type a, logic done);
		logic [63:0] old;
		old = tgtQ[63:0];
		d = {$random(seed), $random(seed)};
		slow <= 1'b1;
		cmd(OP_SET_ZONE, 8'h80, 5'h0, 1'b1);
		cmd(OP_WRITE_USER, 8'h00, 5'h7, 1'b1);
		do @(posedge mclk); while (!(eeReq === 1'b1 && eeArea === a));
		arst_n <= 1'b0;
		expQ.delete();
		@(posedge mclk);
		arst_n <= 1'b1;
		idle();
		chk(tgtQ[63:0], done ? d : old);
		chk({flagQ, tear_protect_enable}, 2'h0);
	endtask
	initial begin
		{mclk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, cmdValid, slow} = '0;
		{command_parameter_byte, cmdAddr, cmdLen, cmdData, d} = '0;
		cmdOp = OP_SET_ZONE;
		wb_sel_i = 4'hf;
		seed = 79783;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		idle();
		wb(1'b0, 4'h4, 32'h0);
		wb(1'b0, 4'hc, 32'h0);
		z = 4'($random(seed));
		cmdAddr <= 16'($random(seed));
		cmd(OP_SET_ZONE, {4'h8, z}, 5'h0, 1'b1);
		cmd(OP_SET_ZONE, 8'h93, 5'h0, 1'b0);
		d = {$random(seed), $random(seed)};
		cmd(OP_WRITE_USER, 8'h00, 5'h7, 1'b1);
		cmd(OP_WRITE_USER, 8'h00, 5'h8, 1'b0);
		idle();
		chk({flagQ, tgtQ[63:0]}, {1'b0, d});
		wb(1'b0, 4'h8, 32'h1);
		wb(1'b0, 4'h4, {24'h0, z, 4'ha});
		cmd(OP_WRITE_CONFIG, 8'h00, 5'h0, 1'b1);
		cmd(OP_WRITE_CONFIG, 8'h80, 5'h0, 1'b0);
		cmd(OP_WRITE_CONFIG, 8'h01, 5'h0, 1'b1);
		cmd(OP_WRITE_CONFIG, 8'h01, 5'h1, 1'b0);
		cmd(OP_WRITE_CONFIG, 8'h02, 5'h0, 1'b0);
		idle();
		wb(1'b1, 4'h0, 32'h1);
		wb(1'b0, 4'h4, {24'h0, z, 4'hb});
		cmd(OP_WRITE_CONFIG, 8'h80, 5'h3, 1'b1);
		cmd(OP_WRITE_CONFIG, 8'h80, 5'h8, 1'b0);
		idle();
		tear(AREA_USER, 1'b1);
		tear(AREA_STAGE, 1'b0);
		d = {$random(seed), $random(seed)};
		cmd(OP_SET_ZONE, 8'h8a, 5'h0, 1'b1);
		cmd(OP_SET_ZONE, 8'h05, 5'h0, 1'b1);
		cmd(OP_WRITE_USER, 8'h00, 5'h8, 1'b1);
		idle();
		chk(tgtQ[63:0], d);
		wb(1'b0, 4'h4, {24'h0, 4'h5, 4'h8});
		wb(1'b0, 4'h8, 32'h0);
		complete_run;
	end
endmodule
bind tswseq_sequencer tswseq_sequencer_props chk_u (.mclk(mclk), .arst_n(arst_n),
	.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdLen(cmdLen),
	.command_parameter_byte(command_parameter_byte), .respValid(respValid),
	.respAck(respAck), .tear_protect_enable(tear_protect_enable), .eeReq(eeReq),
	.eeWrite(eeWrite), .eeArea(eeArea), .eeWdata(eeWdata));
`default_nettype wire

// File: tswseq_cfg.svh
`ifndef TSWSEQ_CFG_SVH
`define TSWSEQ_CFG_SVH

`define TSWSEQ_ADR_CTRL 4'h0
`define TSWSEQ_ADR_STATUS 4'h4
`define TSWSEQ_ADR_COUNT 4'h8
`define TSWSEQ_CTRL_LARGE 0
`define TSWSEQ_CTRL_RESET 1'h0
`define TSWSEQ_ZONE_PROT_BIT 7
`define TSWSEQ_ZONE_ZERO_HI 6
`define TSWSEQ_ZONE_ZERO_LO 4
`define TSWSEQ_CFG_PROT 8'h80
`define TSWSEQ_CFG_NORMAL 8'h00
`define TSWSEQ_CFG_FUSE 8'h01
`define TSWSEQ_PROT_MAX_LEN 5'h07

`endif

// File: tswseq_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Nonvolatile store
// ----
module tswseq_nvm_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic eeReq,
	input wire logic eeWrite,
	input wire tswseq_pkg::tswseq_area_type eeArea,
	input wire logic [15:0] eeAddr,
	input wire logic [4:0] eeLen,
	input wire tswseq_pkg::tswseq_area_type eeTag,
	input wire logic [255:0] eeWdata,
	output logic eeDone,
	output logic [255:0] eeRdata,
	output logic [15:0] eeRaddr,
	output logic [4:0] eeRlen,
	output tswseq_pkg::tswseq_area_type eeRtag,
	output logic flagQ,
	output logic [255:0] tgtQ
);
	import tswseq_pkg::*;
	logic busyQ;
	logic [2:0] waitQ;
	logic [255:0] stData;
	initial begin
		{flagQ, busyQ, eeDone, waitQ} = '0;
		{eeRdata, stData, tgtQ, eeRaddr, eeRlen} = '0;
		eeRtag = AREA_USER;
	end
	// Cells survive a reset; a reset only aborts the access in flight.
	always @(posedge mclk) begin
		eeDone <= 1'b0;
		eeRdata <= ~eeRdata;
		if (!arst_n) begin
			busyQ <= 1'b0;
		end else if (eeReq) begin
			busyQ <= 1'b1;
			waitQ <= slow ? 3'h6 : 3'h1;
		end else if (busyQ && waitQ > 3'h1) begin
			waitQ <= waitQ - 3'h1;
		end else if (busyQ) begin
			busyQ <= 1'b0;
			eeDone <= 1'b1;
			eeRdata <= (eeArea == AREA_FLAG) ? {255'h0, flagQ} : stData;
			if (eeWrite && eeArea == AREA_FLAG) begin
				flagQ <= eeWdata[0];
			end else if (eeWrite && eeArea == AREA_STAGE) begin
				stData <= eeWdata;
				eeRaddr <= eeAddr;
				eeRlen <= eeLen;
				eeRtag <= eeTag;
			end else if (eeWrite) begin
				tgtQ <= eeWdata;
			end
		end
	end
endmodule
`default_nettype wire

// File: tswseq_pkg.sv
package tswseq_pkg;

	typedef enum logic [1:0] {
		OP_SET_ZONE,
		OP_WRITE_USER,
		OP_WRITE_CONFIG
	} tswseq_op_type;

	typedef enum logic [1:0] {
		AREA_USER,
		AREA_CONFIG,
		AREA_STAGE,
		AREA_FLAG
	} tswseq_area_type;

	typedef enum {
		ST_BOOT_FLAG,
		ST_BOOT_STAGE,
		ST_IDLE,
		ST_STAGE,
		ST_SET_FLAG,
		ST_COPY,
		ST_CLEAR_FLAG,
		ST_DIRECT,
		ST_RESP
	} tswseq_state_type;

endpackage

// File: tswseq_sequencer.sv
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tswseq_cfg.svh"

module tswseq_sequencer (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire tswseq_pkg::tswseq_op_type cmdOp,
	input wire logic [7:0] command_parameter_byte,
	input wire logic [15:0] cmdAddr,
	input wire logic [4:0] cmdLen,
	input wire logic [255:0] cmdData,
	output logic respValid,
	output logic respAck,
	output logic tear_protect_enable,
	output logic [3:0] zoneSel,
	output logic eeReq,
	output logic eeWrite,
	output tswseq_pkg::tswseq_area_type eeArea,
	output logic [15:0] eeAddr,
	output logic [4:0] eeLen,
	output tswseq_pkg::tswseq_area_type eeTag,
	output logic [255:0] eeWdata,
	input wire logic eeDone,
	input wire logic [255:0] eeRdata,
	input wire logic [15:0] eeRaddr,
	input wire logic [4:0] eeRlen,
	input wire tswseq_pkg::tswseq_area_type eeRtag
);
	import tswseq_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	tswseq_state_type state_q;
	logic issued_q;
	logic largeVariant_q;
	logic [15:0] protCount_q;
	logic [15:0] tgtAddr_q;
	logic [4:0] tgtLen_q;
	tswseq_area_type tgtArea_q;
	logic [255:0] tgtData_q;
	logic ackPending_q;
	logic stepState;
	logic wbHit;
	logic cmdTake;

	function automatic logic isStep(input tswseq_state_type s);
		isStep = (s == ST_BOOT_FLAG) || (s == ST_BOOT_STAGE) || (s == ST_STAGE) ||
			(s == ST_SET_FLAG) || (s == ST_COPY) || (s == ST_CLEAR_FLAG) ||
			(s == ST_DIRECT);
	endfunction

	assign stepState = isStep(state_q);
	assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// The reader is held off until the power-up recovery has finished.
	// commands blocked
	assign cmdReady = (state_q == ST_IDLE);
	assign cmdTake = cmdValid && cmdReady;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	logic decOk;
	logic decProt;
	logic decWrite;
	logic decZone;
	tswseq_area_type decArea;

	always_comb begin
		decOk = 1'b0;
		decProt = 1'b0;
		decWrite = 1'b0;
		decZone = 1'b0;
		decArea = AREA_USER;
		case (cmdOp)
			OP_SET_ZONE: begin
				decZone = (command_parameter_byte[`TSWSEQ_ZONE_ZERO_HI:`TSWSEQ_ZONE_ZERO_LO] == 3'h0);
				decOk = decZone;
			end
			OP_WRITE_USER: begin
				decWrite = 1'b1;
				decProt = tear_protect_enable;
				decOk = 1'b1;
			end
			OP_WRITE_CONFIG: begin
				decWrite = 1'b1;
				decArea = AREA_CONFIG;
				if (command_parameter_byte == `TSWSEQ_CFG_NORMAL) begin
					decOk = 1'b1;
				end else if (command_parameter_byte == `TSWSEQ_CFG_PROT) begin
					decOk = largeVariant_q;
					decProt = 1'b1;
				end else if (command_parameter_byte == `TSWSEQ_CFG_FUSE) begin
					decOk = (cmdLen == 5'h00);
				end
			end
			default: begin
				decOk = 1'b0;
			end
		endcase
		if (decProt && (cmdLen > `TSWSEQ_PROT_MAX_LEN)) begin
			decOk = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Protect mode and zone
	// ------------------------------------------------------------------
	// Only a zone select from the reader touches the mode; the register file cannot.
	// reader-only mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tear_protect_enable <= 1'b0;
			zoneSel <= 4'h0;
		end else if (cmdTake && decZone) begin
			tear_protect_enable <= command_parameter_byte[`TSWSEQ_ZONE_PROT_BIT];
			zoneSel <= command_parameter_byte[3:0];
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// The flag is written only after the staged record is complete, and cleared
	// only after the final copy, so a torn sequence either loses the write or
	// replays it from the staging record at the next power-up.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_BOOT_FLAG;
		end else begin
			case (state_q)
				ST_BOOT_FLAG: begin
					if (issued_q && eeDone) begin
						state_q <= eeRdata[0] ? ST_BOOT_STAGE : ST_IDLE;
					end
				end
				ST_BOOT_STAGE, ST_SET_FLAG: begin
					if (issued_q && eeDone) begin
						state_q <= ST_COPY;
					end
				end
				ST_IDLE: begin
					if (cmdTake) begin
						if (decOk && decWrite) begin
							state_q <= decProt ? ST_STAGE : ST_DIRECT;
						end else begin
							state_q <= ST_RESP;
						end
					end
				end
				ST_STAGE: begin
					if (issued_q && eeDone) begin
						state_q <= ST_SET_FLAG;
					end
				end
				ST_COPY: begin
					if (issued_q && eeDone) begin
						state_q <= ST_CLEAR_FLAG;
					end
				end
				ST_CLEAR_FLAG: begin
					if (issued_q && eeDone) begin
						state_q <= ackPending_q ? ST_RESP : ST_IDLE;
					end
				end
				ST_DIRECT: begin
					if (issued_q && eeDone) begin
						state_q <= ST_RESP;
					end
				end
				ST_RESP: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Latched command, or the record recovered from the staging memory.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tgtAddr_q <= 16'h0000;
			tgtLen_q <= 5'h00;
			tgtArea_q <= AREA_USER;
			tgtData_q <= '0;
			ackPending_q <= 1'b0;
			respAck <= 1'b0;
		end else if (cmdTake) begin
			tgtAddr_q <= cmdAddr;
			tgtLen_q <= cmdLen;
			tgtArea_q <= decArea;
			tgtData_q <= cmdData;
			ackPending_q <= 1'b1;
			respAck <= decOk;
		end else if ((state_q == ST_BOOT_STAGE) && issued_q && eeDone) begin
			tgtAddr_q <= eeRaddr;
			tgtLen_q <= eeRlen;
			tgtArea_q <= eeRtag;
			tgtData_q <= eeRdata;
			ackPending_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			respValid <= 1'b0;
		end else begin
			respValid <= ((state_q == ST_IDLE) && cmdTake && !(decOk && decWrite)) ||
				(((state_q == ST_CLEAR_FLAG) && ackPending_q) || (state_q == ST_DIRECT)) &&
				issued_q && eeDone;
		end
	end

	// ------------------------------------------------------------------
	// Nonvolatile access
	// ------------------------------------------------------------------
	// One programming step per state keeps a protected write at four steps.
	// four steps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			issued_q <= 1'b0;
			eeReq <= 1'b0;
		end else begin
			eeReq <= stepState && !issued_q;
			if (stepState && !issued_q) begin
				issued_q <= 1'b1;
			end else if (issued_q && eeDone) begin
				issued_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			eeWrite <= 1'b0;
			eeArea <= AREA_FLAG;
			eeAddr <= 16'h0000;
			eeLen <= 5'h00;
			eeTag <= AREA_USER;
			eeWdata <= '0;
		end else if (stepState && !issued_q) begin
			eeAddr <= tgtAddr_q;
			eeLen <= tgtLen_q;
			eeTag <= tgtArea_q;
			eeWdata <= tgtData_q;
			eeWrite <= (state_q != ST_BOOT_FLAG) && (state_q != ST_BOOT_STAGE);
			case (state_q)
				ST_BOOT_FLAG, ST_SET_FLAG, ST_CLEAR_FLAG: begin
					eeArea <= AREA_FLAG;
					eeWdata <= {255'h0, (state_q == ST_SET_FLAG)};
				end
				ST_BOOT_STAGE, ST_STAGE: begin
					eeArea <= AREA_STAGE;
				end
				default: begin
					eeArea <= tgtArea_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			largeVariant_q <= `TSWSEQ_CTRL_RESET;
		end else if (wbHit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `TSWSEQ_ADR_CTRL)) begin
			largeVariant_q <= wb_dat_i[`TSWSEQ_CTRL_LARGE];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			protCount_q <= 16'h0000;
		end else if ((state_q == ST_SET_FLAG) && issued_q && eeDone) begin
			protCount_q <= protCount_q + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wbHit;
			wb_dat_o <= 32'h00000000;
			if (wbHit && !wb_we_i) begin
				case (wb_adr_i)
					`TSWSEQ_ADR_CTRL: begin
						wb_dat_o <= {31'h0, largeVariant_q};
					end
					`TSWSEQ_ADR_STATUS: begin
						wb_dat_o <= {24'h0, zoneSel, ackPending_q, !cmdReady,
							tear_protect_enable, largeVariant_q};
					end
					`TSWSEQ_ADR_COUNT: begin
						wb_dat_o <= {16'h0, protCount_q};
					end
					default: begin
						wb_dat_o <= 32'h00000000;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// File: tswseq_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module tswseq_sequencer_props (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire tswseq_pkg::tswseq_op_type cmdOp,
	input wire logic [7:0] command_parameter_byte,
	input wire logic [4:0] cmdLen,
	input wire logic respValid,
	input wire logic respAck,
	input wire logic tear_protect_enable,
	input wire logic eeReq,
	input wire logic eeWrite,
	input wire tswseq_pkg::tswseq_area_type eeArea,
	input wire logic [255:0] eeWdata
);
	import tswseq_pkg::*;
	logic take;
	logic flagWrQ;
	logic [7:0] p;
	assign take = cmdValid && cmdReady;
	assign p = command_parameter_byte;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flagWrQ <= 1'b0;
		end else if (eeReq && eeWrite && eeArea == AREA_FLAG) begin
			flagWrQ <= eeWdata[0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_zone_update: assert property (take && cmdOp == OP_SET_ZONE && p[6:4] == 3'h0
		|=> respValid && respAck && tear_protect_enable == $past(p[7])) else $error("zone");
	a_zone_bad: assert property (take && cmdOp == OP_SET_ZONE && p[6:4] != 3'h0
		|=> respValid && !respAck && $stable(tear_protect_enable)) else $error("bad zone");
	a_boot_flag_read: assert property ($rose(arst_n) |-> !tear_protect_enable
		&& !cmdReady ##1 eeReq && !eeWrite && eeArea == AREA_FLAG) else $error("boot");
	a_long_refused: assert property (take && cmdLen > 5'h7 && ((cmdOp == OP_WRITE_USER
		&& tear_protect_enable) || (cmdOp == OP_WRITE_CONFIG && p == 8'h80))
		|=> respValid && !respAck) else $error("long write");
	a_stage_first: assert property (take && cmdOp == OP_WRITE_USER && tear_protect_enable
		&& cmdLen <= 5'h7 |=> ##1 eeReq && eeWrite && eeArea == AREA_STAGE) else $error("stage");
	a_copy_flag_set: assert property (eeReq && eeWrite && eeArea == AREA_USER
		&& tear_protect_enable |-> flagWrQ) else $error("copy without flag");
	a_resp_flag_clear: assert property (respValid |-> !flagWrQ) else $error("early ack");
	a_cfg_bad_byte: assert property (take && cmdOp == OP_WRITE_CONFIG
		&& !(p inside {8'h00, 8'h80, 8'h01}) |=> respValid && !respAck && !eeReq)
		else $error("config byte");
	a_busy_no_cmd: assert property (eeReq |-> !cmdReady) else $error("ready while busy");
	c_boot_copy: cover property (eeReq && !eeWrite && eeArea == AREA_STAGE);
	c_prot_ack: cover property (respValid && respAck && tear_protect_enable);
	c_nack: cover property (respValid && !respAck);
endmodule
`default_nettype wire
